// ==== rtl/pdsl_loader.sv ====
// serial loaded reference, swallow and main dividers with phase and lock detection
`timescale 1ns/1ps
module pdsl_loader
   import pdsl_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_serial_clock,
   input wire logic i_serial_data,
   input wire logic i_latch_enable,
   input wire logic i_module_select_0,
   input wire logic i_module_select_1,
   input wire logic i_module_select_2,
   input wire logic i_reference_clock_input,
   input wire logic i_prescaler_feedback,
   input wire logic i_internal_ref_select,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_prescale_mod65,
   output logic o_phase_error_up,
   output logic o_phase_error_down,
   output logic o_lock_indicator,
   output logic o_locked_flag,
   output logic o_fault_led,
   output logic o_internal_osc_enable,
   output logic o_irq
);
   logic [PIN_N-1:0] pins;
   logic [PIN_N-1:0] s1_r, s2_r, s3_r, flt_r, flt_d_r, rise;
   logic sel_ok, sclk_go, le_go;
   logic [SH_W-1:0] shreg_r;
   logic [R_W-1:0] r_lat_r, r_cnt_r;
   logic [N_W-1:0] n_lat_r, n_cnt_r;
   logic [A_W-1:0] a_lat_r, a_cnt_r, a_nxt;
   logic fr_r, fv_r;
   logic up_r, down_r;
   logic [7:0] err_run_r;
   logic err_big_r;
   logic [3:0] good_r;
   logic locked_r;
   logic [EV_N-1:0] evt, status_r, enable_r;
   logic [31:0] rdata_nxt;

   assign pins = {i_internal_ref_select, i_module_select_2, i_module_select_1,
                  i_module_select_0, i_prescaler_feedback, i_reference_clock_input,
                  i_latch_enable, i_serial_data, i_serial_clock};

   // three stage synchroniser; a level counts once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         flt_r <= '0;
         flt_d_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_r <= (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
         flt_d_r <= flt_r;
      end
   end
   assign rise = flt_r & ~flt_d_r;

   assign sel_ok = ({flt_r[PIN_SEL2], flt_r[PIN_SEL1], flt_r[PIN_SEL0]} == SEL_CODE);
   assign sclk_go = rise[PIN_SCLK] & sel_ok;
   assign le_go = rise[PIN_LE] & sel_ok;

   // serial shift register, last bit in sits at the control position
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         shreg_r <= '0;
      end else if (sclk_go) begin
         shreg_r <= {shreg_r[SH_W-2:0], flt_r[PIN_SDATA]};
      end
   end

   // holding latches; shifting never disturbs them
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r_lat_r <= R_RST;
         n_lat_r <= N_RST;
         a_lat_r <= A_RST;
      end else if (le_go && shreg_r[CTL_BIT]) begin
         r_lat_r <= shreg_r[R_LSB +: R_W];
         n_lat_r <= shreg_r[N_LSB +: N_W];
         a_lat_r <= shreg_r[A_LSB +: A_W];
      end
   end

   // reference divider
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r_cnt_r <= '0;
         fr_r <= 1'b0;
      end else begin
         fr_r <= 1'b0;
         if (rise[PIN_REF]) begin
            if ((r_cnt_r + 14'h0001) >= r_lat_r) begin
               r_cnt_r <= '0;
               fr_r <= 1'b1;
            end else begin
               r_cnt_r <= r_cnt_r + 14'h0001;
            end
         end
      end
   end

   // swallow and main counters on prescaler feedback
   always_comb begin
      a_nxt = a_cnt_r;
      if (rise[PIN_FB]) begin
         if ((n_cnt_r + 10'h001) >= n_lat_r) begin
            a_nxt = a_lat_r;
         end else if (a_cnt_r != '0) begin
            a_nxt = a_cnt_r - 7'h01;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         n_cnt_r <= '0;
         a_cnt_r <= A_RST;
         fv_r <= 1'b0;
         o_prescale_mod65 <= 1'b0;
      end else begin
         fv_r <= 1'b0;
         a_cnt_r <= a_nxt;
         o_prescale_mod65 <= (a_nxt != '0);
         if (rise[PIN_FB]) begin
            if ((n_cnt_r + 10'h001) >= n_lat_r) begin
               n_cnt_r <= '0;
               fv_r <= 1'b1;
            end else begin
               n_cnt_r <= n_cnt_r + 10'h001;
            end
         end
      end
   end

   // phase comparator: up for reference leading, down for feedback leading
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         up_r <= 1'b0;
         down_r <= 1'b0;
      end else begin
         up_r <= (up_r | fr_r) & ~(down_r | fv_r);
         down_r <= (down_r | fv_r) & ~(up_r | fr_r);
      end
   end
   assign o_phase_error_up = up_r;
   assign o_phase_error_down = down_r;

   // lock detector: every comparison period with a short error pulse counts good
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         err_run_r <= '0;
         err_big_r <= 1'b0;
         good_r <= '0;
         locked_r <= 1'b0;
      end else begin
         if (up_r | down_r) begin
            if (err_run_r != 8'hff) begin
               err_run_r <= err_run_r + 8'h01;
            end
         end else begin
            err_run_r <= '0;
         end
         if (fr_r) begin
            err_big_r <= 1'b0;
            if (err_big_r || (err_run_r > LOCK_WIN_CYC)) begin
               good_r <= '0;
               locked_r <= 1'b0;
            end else if (good_r >= LOCK_PERIODS - 4'h1) begin
               locked_r <= 1'b1;
            end else begin
               good_r <= good_r + 4'h1;
            end
         end else if (err_run_r > LOCK_WIN_CYC) begin
            err_big_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_lock_indicator <= 1'b0;
         o_locked_flag <= 1'b0;
         o_fault_led <= 1'b1;
         o_internal_osc_enable <= 1'b0;
      end else begin
         o_lock_indicator <= locked_r;
         o_locked_flag <= locked_r;
         o_fault_led <= ~locked_r;
         o_internal_osc_enable <= flt_r[PIN_REFSEL];
      end
   end

   // events for the interrupt status
   assign evt[EV_LOCK_GAIN] = locked_r & ~o_lock_indicator;
   assign evt[EV_LOCK_LOSS] = ~locked_r & o_lock_indicator;
   assign evt[EV_LOAD_OK] = le_go & shreg_r[CTL_BIT];
   assign evt[EV_LOAD_BAD] = le_go & ~shreg_r[CTL_BIT];

   // sticky status, a new event wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         status_r <= '0;
      end else if (i_wr && (i_addr == ADDR_CLEAR)) begin
         status_r <= (status_r & ~i_wdata[EV_N-1:0]) | evt;
      end else begin
         status_r <= status_r | evt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         enable_r <= EV_ENABLE_RST;
      end else if (i_wr && (i_addr == ADDR_ENABLE)) begin
         enable_r <= i_wdata[EV_N-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(status_r & enable_r);
      end
   end

   // read decode; unmapped and write-only addresses read zero
   always_comb begin
      rdata_nxt = '0;
      if (i_addr == ADDR_STATUS) begin
         rdata_nxt[EV_N-1:0] = status_r;
      end else if (i_addr == ADDR_ENABLE) begin
         rdata_nxt[EV_N-1:0] = enable_r;
      end else if (i_addr == ADDR_REF_DIV) begin
         rdata_nxt[R_W-1:0] = r_lat_r;
      end else if (i_addr == ADDR_FB_DIV) begin
         rdata_nxt[N_W-1:0] = n_lat_r;
         rdata_nxt[FB_A_POS +: A_W] = a_lat_r;
      end else if (i_addr == ADDR_STATE) begin
         rdata_nxt[ST_LOCK] = locked_r;
         rdata_nxt[ST_MOD65] = o_prescale_mod65;
         rdata_nxt[ST_SEL] = sel_ok;
         rdata_nxt[ST_OSC] = o_internal_osc_enable;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= '0;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   shift_gate_a: assert property ($changed(shreg_r) && !$past(i_rst) |-> $past(sclk_go))
      else $error("shift register moved without a selected serial clock");
   shift_in_a: assert property (sclk_go |=> shreg_r[0] == $past(flt_r[PIN_SDATA]))
      else $error("serial bit not captured");
   latch_hold_a: assert property ($changed(r_lat_r) |-> $past(le_go && shreg_r[CTL_BIT]))
      else $error("divisor changed outside a latch transfer");
   latch_value_a: assert property (le_go && shreg_r[CTL_BIT] |=>
      r_lat_r == $past(shreg_r[R_LSB +: R_W]) && a_lat_r == $past(shreg_r[A_LSB +: A_W]))
      else $error("latched divisors do not match stream");
   latch_n_a: assert property (le_go && shreg_r[CTL_BIT] |=>
      n_lat_r == $past(shreg_r[N_LSB +: N_W]))
      else $error("main divisor not latched from stream");
   latch_ctl_a: assert property (le_go && !shreg_r[CTL_BIT] |=> $stable(n_lat_r))
      else $error("latched with control bit zero");
   ref_wrap_a: assert property (fr_r |-> r_cnt_r == '0)
      else $error("reference pulse without counter wrap");
   fb_mod_a: assert property (fv_r |-> o_prescale_mod65 == ($past(a_lat_r) != '0))
      else $error("modulus not reloaded with swallow count");
   pfd_up_a: assert property (fr_r && !fv_r && !down_r |=> up_r && !down_r)
      else $error("reference lead did not pump up");
   pfd_dn_a: assert property (fv_r && !fr_r && !up_r |=> down_r && !up_r)
      else $error("feedback lead did not pump down");
   lock_src_a: assert property (o_lock_indicator == $past(locked_r))
      else $error("lock indicator does not follow detector");
   lock_out_a: assert property (o_locked_flag == o_lock_indicator &&
      o_fault_led == !o_locked_flag)
      else $error("fault indicator disagrees with lock flag");
   lock_lag_a: assert property ($rose(locked_r) |=> o_locked_flag ##0 !o_fault_led)
      else $error("lock flag did not follow detector");
   status_set_a: assert property (|evt |=> |status_r)
      else $error("event lost from status");
   irq_level_a: assert property (o_irq == |$past(status_r & enable_r))
      else $error("interrupt level disagrees with enabled status");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside the answer cycle");

   load_ok_c: cover property (le_go && shreg_r[CTL_BIT]);
   lock_gain_c: cover property ($rose(o_locked_flag));
   mod_switch_c: cover property ($fell(o_prescale_mod65));
   irq_c: cover property ($rose(o_irq));
endmodule

// ==== rtl/pdsl_pkg.sv ====
// constants, register map and field layout for the divider serial loader
package pdsl_pkg;
   localparam int CLK_MHZ = 200;
   localparam int LOCK_WIN_NS = 50;
   localparam int LOCK_WIN_CYC_I = (LOCK_WIN_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] LOCK_WIN_CYC = 8'(LOCK_WIN_CYC_I);
   localparam logic [3:0] LOCK_PERIODS = 4'h8;

   localparam int R_W = 14;
   localparam int N_W = 10;
   localparam int A_W = 7;
   localparam int SH_W = R_W + N_W + A_W + 1;
   localparam int R_LSB = N_W + A_W + 1;
   localparam int N_LSB = A_W + 1;
   localparam int A_LSB = 1;
   localparam int CTL_BIT = 0;

   localparam logic [R_W-1:0] R_RST = 14'h0001;
   localparam logic [N_W-1:0] N_RST = 10'h001;
   localparam logic [A_W-1:0] A_RST = 7'h00;

   // select code as {select_2, select_1, select_0}
   localparam logic [2:0] SEL_CODE = 3'h2;

   // synchronised pin positions
   localparam int PIN_SCLK = 0;
   localparam int PIN_SDATA = 1;
   localparam int PIN_LE = 2;
   localparam int PIN_REF = 3;
   localparam int PIN_FB = 4;
   localparam int PIN_SEL0 = 5;
   localparam int PIN_SEL1 = 6;
   localparam int PIN_SEL2 = 7;
   localparam int PIN_REFSEL = 8;
   localparam int PIN_N = 9;

   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CLEAR = 8'h04;
   localparam logic [7:0] ADDR_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_REF_DIV = 8'h0c;
   localparam logic [7:0] ADDR_FB_DIV = 8'h10;
   localparam logic [7:0] ADDR_STATE = 8'h14;

   // field positions inside the read words
   localparam int FB_A_POS = 16;
   localparam int ST_LOCK = 0;
   localparam int ST_MOD65 = 1;
   localparam int ST_SEL = 2;
   localparam int ST_OSC = 3;

   localparam int EV_N = 4;
   localparam int EV_LOCK_GAIN = 0;
   localparam int EV_LOCK_LOSS = 1;
   localparam int EV_LOAD_OK = 2;
   localparam int EV_LOAD_BAD = 3;
   localparam logic [EV_N-1:0] EV_ENABLE_RST = 4'h0;
endpackage

// ==== verif/pdsl_ctl_model.sv ====
// station controller and prescaler model driving the loader pins
`timescale 1ns/1ps
module pdsl_ctl_model (
   input wire logic i_clk,
   input wire logic [7:0] i_ref_half,
   input wire logic [7:0] i_fb_half,
   output logic o_sclk,
   output logic o_sdata,
   output logic o_le,
   output logic [2:0] o_sel,
   output logic o_ref,
   output logic o_fb
);
   logic [7:0] rc = 8'h00;
   logic [7:0] fc = 8'h00;
   logic fb_own = 1'b0;
   initial begin
      o_sclk = 1'b0;
      o_sdata = 1'b0;
      o_le = 1'b0;
      o_sel = 3'h0;
      o_ref = 1'b0;
   end
   // half period of zero makes the feedback an exact copy of the reference
   assign o_fb = (i_fb_half == 8'h00) ? o_ref : fb_own;
   always @(posedge i_clk) begin
      rc <= (rc + 8'h01 >= i_ref_half) ? 8'h00 : rc + 8'h01;
      fc <= (fc + 8'h01 >= i_fb_half) ? 8'h00 : fc + 8'h01;
      if (rc + 8'h01 >= i_ref_half) o_ref <= ~o_ref;
      if (fc + 8'h01 >= i_fb_half) fb_own <= ~fb_own;
   end
   // six clocks per level keeps every phase past the pin synchronisers
   task automatic shift_word(input logic [31:0] w, input logic [2:0] sel);
      @(posedge i_clk);
      o_sel <= sel;
      repeat (6) @(posedge i_clk);
      for (int i = 31; i >= 0; i--) begin
         o_sdata <= w[i];
         repeat (6) @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (6) @(posedge i_clk);
         o_sclk <= 1'b0;
      end
      o_sdata <= ~w[0];
   endtask
   task automatic pulse_le();
      @(posedge i_clk);
      o_le <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_le <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_sel <= 3'h0;
   endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the divider serial loader
`timescale 1ns/1ps
module testbench import pdsl_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, sdata, le, ref_in, fb_in;
   logic int_sel = 1'b0;
   logic [2:0] sel;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] ref_half = 8'h04;
   logic [7:0] fb_half = 8'h14;
   logic [31:0] rdata;
   logic mod65, pe_up, pe_dn, lock_ind, locked, fault, osc_en, irq;
   int err_count = 0;
   int num_checks = 0;
   always #2.5 clk = ~clk;
   pdsl_ctl_model pdsl_ctl_model_inst (.i_clk(clk), .i_ref_half(ref_half),
      .i_fb_half(fb_half), .o_sclk(sclk), .o_sdata(sdata), .o_le(le),
      .o_sel(sel), .o_ref(ref_in), .o_fb(fb_in));
   pdsl_loader pdsl_loader_inst (.i_clk(clk), .i_rst(rst), .i_serial_clock(sclk),
      .i_serial_data(sdata), .i_latch_enable(le), .i_module_select_0(sel[0]),
      .i_module_select_1(sel[1]), .i_module_select_2(sel[2]),
      .i_reference_clock_input(ref_in), .i_prescaler_feedback(fb_in),
      .i_internal_ref_select(int_sel), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .o_prescale_mod65(mod65), .o_phase_error_up(pe_up),
      .o_phase_error_down(pe_dn), .o_lock_indicator(lock_ind), .o_locked_flag(locked),
      .o_fault_led(fault), .o_internal_osc_enable(osc_en), .o_irq(irq));
   function automatic logic [31:0] mkw(logic [13:0] r, logic [9:0] n, logic [6:0] a,
      logic c);
      return {r, n, a, c};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdata & m, exp);
   endtask
   task automatic load(input logic [31:0] w, input logic [2:0] s);
      bus(1'b1, ADDR_CLEAR, 32'hf);
      pdsl_ctl_model_inst.shift_word(w, s);
      pdsl_ctl_model_inst.pulse_le();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic test_reset();
      chk(32'({fault, locked, lock_ind, irq}), 32'h8);
      rdm(ADDR_REF_DIV, 32'hffffffff, {18'h0, R_RST});
      rdm(ADDR_FB_DIV, 32'hffffffff, {9'h0, A_RST, 6'h0, N_RST});
      $display("done: reset");
   endtask
   task automatic test_load();
      bus(1'b1, ADDR_CLEAR, 32'hf);
      pdsl_ctl_model_inst.shift_word(mkw(14'h1a5c, 10'h2b3, 7'h4d, 1'b1), SEL_CODE);
      rdm(ADDR_REF_DIV, 32'hffffffff, {18'h0, R_RST});
      pdsl_ctl_model_inst.pulse_le();
      rdm(ADDR_REF_DIV, 32'hffffffff, 32'h1a5c);
      rdm(ADDR_FB_DIV, 32'hffffffff, 32'h004d02b3);
      rdm(ADDR_STATUS, 32'hc, 32'h4);
      $display("done: load");
   endtask
   task automatic test_refused();
      logic [2:0] bad [2] = '{3'h5, 3'h3};
      foreach (bad[i]) begin
         load(mkw(14'h0007, 10'h007, 7'h07, 1'b1), bad[i]);
         rdm(ADDR_REF_DIV, 32'hffffffff, 32'h1a5c);
         rdm(ADDR_STATUS, 32'hc, 32'h0);
      end
      load(mkw(14'h0007, 10'h007, 7'h07, 1'b0), SEL_CODE);
      rdm(ADDR_REF_DIV, 32'hffffffff, 32'h1a5c);
      rdm(ADDR_STATUS, 32'hc, 32'h8);
      $display("done: refused");
   endtask
   task automatic test_irq();
      bus(1'b1, ADDR_ENABLE, 32'h4);
      rdm(ADDR_ENABLE, 32'hf, 32'h4);
      bus(1'b1, ADDR_REF_DIV, 32'h0);
      bus(1'b1, 8'h40, 32'hffffffff);
      rdm(8'h40, 32'hffffffff, 32'h0);
      rdm(ADDR_REF_DIV, 32'hffffffff, 32'h1a5c);
      load(mkw(14'h0001, 10'h003, 7'h01, 1'b1), SEL_CODE);
      chk(32'(irq), 32'h1);
      bus(1'b1, ADDR_CLEAR, 32'h4);
      @(posedge clk);
      #1;
      chk(32'(irq), 32'h0);
      $display("done: irq");
   endtask
   task automatic test_mod65();
      logic hi = 1'b0;
      logic lo = 1'b0;
      int n_hi = 0;
      @(posedge clk);
      fb_half <= 8'h04;
      repeat (48) @(posedge clk);
      // swallow 1 of main 3 prescaler periods, 8 clocks each, over 10 cycles
      repeat (240) begin
         @(posedge clk);
         #1;
         hi = hi | mod65;
         lo = lo | ~mod65;
         if (mod65 === 1'b1) begin
            n_hi++;
         end
      end
      chk(32'({hi, lo}), 32'h3);
      chk(32'(n_hi), 32'h50);
      $display("done: mod65");
   endtask
   task automatic test_lock();
      logic pe = 1'b0;
      int n = 0;
      load(mkw(14'h0001, 10'h001, 7'h00, 1'b1), SEL_CODE);
      @(posedge clk);
      fb_half <= 8'h00;
      // let the switch-over glitch on the feedback pass before judging
      repeat (40) @(posedge clk);
      while (locked !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      repeat (32) begin
         @(posedge clk);
         #1;
         pe = pe | pe_up | pe_dn;
      end
      chk(32'(pe), 32'h0);
      chk(32'({lock_ind, fault}), 32'h2);
      rdm(ADDR_STATE, 32'h1, 32'h1);
      @(posedge clk);
      fb_half <= 8'h14;
      n = 0;
      while (locked !== 1'b0 && n < 2000) begin
         @(posedge clk);
         pe = pe | pe_up | pe_dn;
         n++;
      end
      repeat (2) @(posedge clk);
      #1;
      chk(32'(pe), 32'h1);
      chk(32'({lock_ind, fault}), 32'h1);
      rdm(ADDR_STATUS, 32'h3, 32'h3);
      $display("done: lock");
   endtask
   task automatic test_osc();
      @(posedge clk);
      int_sel <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(32'(osc_en), 32'h1);
      rdm(ADDR_STATE, 32'h8, 32'h8);
      @(posedge clk);
      int_sel <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk(32'(osc_en), 32'h0);
      rdm(ADDR_STATE, 32'h8, 32'h0);
      $display("done: osc select");
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      test_reset();
      test_load();
      test_refused();
      test_irq();
      test_mod65();
      test_lock();
      test_osc();
      report_and_stop();
   end
endmodule
